// [design/uefc_map.svh]
// Register offsets, field positions, reset values for the enhanced feature control block
// Assumes byte addressing on an APB bus with 32-bit data, one register per aligned word
`ifndef UEFC_MAP_SVH
`define UEFC_MAP_SVH
// Byte offsets
`define UEFC_A_LINE_CTRL 8'h00
`define UEFC_A_SCRATCH 8'h04
`define UEFC_A_DIV_LO 8'h08
`define UEFC_A_DIV_HI 8'h0C
`define UEFC_A_DIV_FRAC 8'h10
`define UEFC_A_PART_ID 8'h14
`define UEFC_A_PART_REV 8'h18
`define UEFC_A_TRIG 8'h1C
`define UEFC_A_OCC_CNT 8'h20
`define UEFC_A_FEAT 8'h24
`define UEFC_A_EXT_EN 8'h28
// Field positions
`define UEFC_FEAT_IR_INV 2
`define UEFC_FEAT_RS485 3
`define UEFC_FEAT_SWAP 6
`define UEFC_FEAT_TRG_TX 7
`define UEFC_EMS_DIR_INV 3
`define UEFC_EMS_LSR_IMM 6
`define UEFC_EMS_SAMP16 7
`define UEFC_EXT_ENH 4
`define UEFC_EXT_SPECIAL 5
`define UEFC_EXT_ARTS 6
`define UEFC_EXT_ACTS 7
// Reset values and keys
`define UEFC_RST_EMS 8'h80
`define UEFC_RST_SCRATCH 8'hFF
`define UEFC_RST_DIV_LO 8'h01
`define UEFC_RST_ZERO 8'h00
`define UEFC_LCR_KEY 8'hBF
`endif

// [design/uefc_pkg.sv]
// Types shared by the enhanced feature control block
// Assumes uefc_map.svh supplies the numeric constants
package uefc_pkg;
   typedef logic [7:0] uefc_byte_t;
   // Direction controller states, Gray along RX -> TX -> HOLD
   typedef enum logic [1:0] {
      UEFC_DIR_RX = 2'b00,
      UEFC_DIR_TX = 2'b01,
      UEFC_DIR_HOLD = 2'b11
   } uefc_dir_e;
   // Level readout count modes
   typedef enum logic [1:0] {
      UEFC_CNT_RX = 2'b00,
      UEFC_CNT_TX = 2'b01,
      UEFC_CNT_RX2 = 2'b10,
      UEFC_CNT_ALT = 2'b11
   } uefc_cnt_e;
endpackage : uefc_pkg

// [design/uefc_dir_ctrl.sv]
// Automatic RS-485 half-duplex direction output
// Assumes tx_load, bit_tick and tx_idle come from the UART core on ref_clk
`timescale 1ns/100ps
module uefc_dir_ctrl
   import uefc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic invert,
   input wire logic tx_load,
   input wire logic tx_idle,
   input wire logic bit_tick,
   output logic dir_out
);
   uefc_dir_e state;

   // Transmit until shifter idle, then wait one bit time
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state <= UEFC_DIR_RX;
      end else begin
         case (state)
            UEFC_DIR_RX: begin
               if (tx_load) state <= UEFC_DIR_TX;
            end
            UEFC_DIR_TX: begin
               if (tx_idle && !tx_load) state <= UEFC_DIR_HOLD;
            end
            UEFC_DIR_HOLD: begin
               if (tx_load) state <= UEFC_DIR_TX;
               else if (bit_tick) state <= UEFC_DIR_RX;
            end
            default: state <= UEFC_DIR_RX;
         endcase
      end
   end

   // Low in transmit, high in receive, swapped by invert
   always_ff @(posedge ref_clk) begin
      if (srst) dir_out <= 1'b1;
      else dir_out <= (state == UEFC_DIR_RX) ? !invert : invert;
   end

   a_dir_tx_level: assert property (@(posedge ref_clk) disable iff (srst)
      (state == UEFC_DIR_TX) && $stable(invert) |=> dir_out == $past(invert))
      else $error("direction output wrong while transmitting");
   a_dir_release: assert property (@(posedge ref_clk) disable iff (srst)
      (state == UEFC_DIR_HOLD) && bit_tick && !tx_load && !invert |=> ##1 dir_out)
      else $error("direction output not released after one bit time");
endmodule : uefc_dir_ctrl

// [design/uefc_rts_ctrl.sv]
// Auto-RTS flow control with selectable hysteresis
// Assumes rx_count is the receive FIFO occupancy on ref_clk
`timescale 1ns/100ps
module uefc_rts_ctrl
   import uefc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic auto_en,
   input wire logic manual_n,
   input wire logic [3:0] hyst_code,
   input wire uefc_byte_t rx_trig,
   input wire uefc_byte_t rx_count,
   output logic rts_flow_n
);
   logic [8:0] upper;
   logic [8:0] lower;
   logic [7:0] hyst;

   // Four-bit code to hysteresis in characters
   function automatic logic [7:0] hyst_chars(input logic [3:0] code);
      case (code)
         4'h0: hyst_chars = 8'h00;
         4'h1: hyst_chars = 8'h04;
         4'h2: hyst_chars = 8'h06;
         4'h3: hyst_chars = 8'h08;
         4'h4: hyst_chars = 8'h08;
         4'h5: hyst_chars = 8'h10;
         4'h6: hyst_chars = 8'h18;
         4'h7: hyst_chars = 8'h20;
         4'h8: hyst_chars = 8'h28;
         4'h9: hyst_chars = 8'h2C;
         4'hA: hyst_chars = 8'h30;
         4'hB: hyst_chars = 8'h34;
         4'hC: hyst_chars = 8'h0C;
         4'hD: hyst_chars = 8'h14;
         4'hE: hyst_chars = 8'h1C;
         default: hyst_chars = 8'h24;
      endcase
   endfunction : hyst_chars

   // Thresholds around the receive trigger level
   always_comb begin
      hyst = hyst_chars(hyst_code);
      upper = {1'b0, rx_trig} + {1'b0, hyst};
      lower = (rx_trig > hyst) ? ({1'b0, rx_trig} - {1'b0, hyst}) : 9'h000;
   end

   // Deassert high at upper level, reassert low below lower level
   always_ff @(posedge ref_clk) begin
      if (srst) rts_flow_n <= 1'b1;
      else if (!auto_en) rts_flow_n <= manual_n;
      else if ({1'b0, rx_count} >= upper) rts_flow_n <= 1'b1;
      else if ({1'b0, rx_count} < lower) rts_flow_n <= 1'b0;
   end

   a_rts_upper: assert property (@(posedge ref_clk) disable iff (srst)
      auto_en && ({1'b0, rx_count} >= upper) |=> rts_flow_n)
      else $error("RTS not deasserted at upper level");
   a_rts_lower: assert property (@(posedge ref_clk) disable iff (srst)
      auto_en && ({1'b0, rx_count} < lower) |=> !rts_flow_n)
      else $error("RTS not reasserted below lower level");
endmodule : uefc_rts_ctrl

// [design/uefc_top.sv]
// Enhanced feature control for one UART channel, registers over APB
// Assumes core status inputs are on ref_clk; rx_pin is asynchronous
// Contract
// - Direction output low in transmit, high in receive; inversion bit swaps.
// - Hysteresis base field resets to zero, selecting zero hysteresis.
// - Four-bit hysteresis code maps to the given character counts.
// - Delayed mode raises line error interrupt when errored char is in holding.
// - Immediate mode raises line error interrupt when errored char enters FIFO.
// - Sampling bit selects 8X at 0, 16X at 1; resets to 1.
// - With swap set, scratch address reads the FIFO level readout.
// - Level readout shows RX, TX or alternating counts per mode field.
// - Alternating mode reads RX first after mode write, then TX, repeating.
// - Divisor is high:low bytes plus fraction over sixteen.
// - Fraction register writable only while enhanced enable bit is set.
// - Trigger register sets custom level; select bit steers to RX or TX.
// - Occupancy count readable only under line control key; RX or TX.
// - IR receive inversion bit chooses idle-low or inverted idle-high input.
// - Direction goes high one bit after last stop; low on FIFO load.
// - In RS-485 mode transmit interrupt waits for empty shift register.
// - Trigger table field selects table A, B, C or D for both directions.
// - Swap clear: plain scratch; set: reads level, writes mode select.
// - Enhanced bits 3:0 select software flow control, dual chars sequential.
// - Auto-RTS deasserts at upper level, reasserts below lower level.
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "uefc_map.svh"
module uefc_top
   import uefc_pkg::*;
#(
   parameter int FIFO_DEPTH = 64,
   parameter logic [7:0] PART_ID = 8'h5C, // Arbitrary value
   parameter logic [7:0] PART_REV = 8'h03 // Arbitrary value
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire uefc_byte_t rx_fifo_count,
   input wire uefc_byte_t tx_fifo_count,
   input wire logic tx_load,
   input wire logic tx_thr_empty,
   input wire logic tx_idle,
   input wire logic bit_tick,
   input wire logic rx_err_push,
   input wire logic rhr_err,
   input wire logic lsr_read,
   input wire logic rts_manual_n,
   input wire logic rx_pin,
   output logic rts_n,
   output logic tx_int,
   output logic lsr_int,
   output logic rx_data_in,
   output logic sample_16x,
   output logic [19:0] baud_divisor_x16,
   output logic [1:0] trigger_table,
   output uefc_byte_t tx_trigger_level,
   output uefc_byte_t rx_trigger_level,
   output logic [3:0] sw_flow_select,
   output logic special_char_en,
   output logic auto_rts_en,
   output logic auto_cts_en
);
   // Configuration check
   if (FIFO_DEPTH < 1 || FIFO_DEPTH > 255) begin : g_bad_depth
      $error("FIFO_DEPTH must fit the 8-bit count registers");
   end

   // Register state, one set per channel instance
   uefc_byte_t line_control;
   uefc_byte_t scratch_store;
   uefc_byte_t enhanced_mode_select;
   uefc_byte_t divisor_low_byte;
   uefc_byte_t divisor_high_byte;
   uefc_byte_t divisor_fraction;
   uefc_byte_t feature_control;
   uefc_byte_t extended_feature_enable;
   logic alt_tx;
   logic err_pend;
   logic rx_meta;
   logic rx_sync;
   logic dir_raw;
   logic rts_flow_n;
   logic wr_acc;
   logic rd_setup;
   logic rd_acc;
   logic swap;
   uefc_byte_t next_rdata;
   logic next_err;
   uefc_byte_t fifo_level_readout;
   uefc_byte_t fifo_occupancy_count;

   // Address decode used by both read and write paths
   function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ref_a);
      is_addr = (a == ref_a);
   endfunction : is_addr

   // Bus phases; zero wait states
   assign pready = 1'b1;
   assign wr_acc = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign rd_acc = psel && penable && !pwrite;
   assign swap = feature_control[`UEFC_FEAT_SWAP];

   // Level readout per count mode
   always_comb begin
      case (uefc_cnt_e'(enhanced_mode_select[1:0]))
         UEFC_CNT_TX: fifo_level_readout = tx_fifo_count;
         UEFC_CNT_ALT: fifo_level_readout = alt_tx ? tx_fifo_count : rx_fifo_count;
         default: fifo_level_readout = rx_fifo_count;
      endcase
   end

   // Occupancy count steered by the trigger select bit
   assign fifo_occupancy_count = feature_control[`UEFC_FEAT_TRG_TX] ? tx_fifo_count : rx_fifo_count;

   // Read mux and error answer
   always_comb begin
      next_rdata = 8'h00;
      next_err = 1'b0;
      case (paddr)
         `UEFC_A_LINE_CTRL: next_rdata = line_control;
         `UEFC_A_SCRATCH: next_rdata = swap ? fifo_level_readout : scratch_store;
         `UEFC_A_DIV_LO: next_rdata = divisor_low_byte;
         `UEFC_A_DIV_HI: next_rdata = divisor_high_byte;
         `UEFC_A_DIV_FRAC: next_rdata = divisor_fraction;
         `UEFC_A_PART_ID: next_rdata = PART_ID;
         `UEFC_A_PART_REV: next_rdata = PART_REV;
         `UEFC_A_TRIG: next_rdata = 8'h00;
         `UEFC_A_OCC_CNT: begin
            if (line_control == `UEFC_LCR_KEY) next_rdata = fifo_occupancy_count;
            else next_err = 1'b1;
         end
         `UEFC_A_FEAT: next_rdata = feature_control;
         `UEFC_A_EXT_EN: next_rdata = extended_feature_enable;
         default: next_err = 1'b1;
      endcase
   end

   // Read data captured in the setup phase
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata <= rd_setup ? {24'h00_0000, next_rdata} : 32'h0000_0000;
         pslverr <= rd_setup ? next_err : !(paddr[1:0] == 2'b00 && paddr <= `UEFC_A_EXT_EN
            && !is_addr(paddr, `UEFC_A_PART_ID) && !is_addr(paddr, `UEFC_A_PART_REV)
            && !is_addr(paddr, `UEFC_A_OCC_CNT));
      end
   end

   // Line control and scratch storage
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         line_control <= `UEFC_RST_ZERO;
         scratch_store <= `UEFC_RST_SCRATCH;
      end else if (wr_acc) begin
         if (is_addr(paddr, `UEFC_A_LINE_CTRL)) line_control <= pwdata[7:0];
         if (is_addr(paddr, `UEFC_A_SCRATCH) && !swap) scratch_store <= pwdata[7:0];
      end
   end

   // Mode select written through the swapped scratch address
   always_ff @(posedge ref_clk) begin
      if (srst) enhanced_mode_select <= `UEFC_RST_EMS;
      else if (wr_acc && is_addr(paddr, `UEFC_A_SCRATCH) && swap) enhanced_mode_select <= pwdata[7:0];
   end

   // Alternating readout: RX first after a mode write
   always_ff @(posedge ref_clk) begin
      if (srst) alt_tx <= 1'b0;
      else if (wr_acc && is_addr(paddr, `UEFC_A_SCRATCH) && swap) alt_tx <= 1'b0;
      else if (rd_acc && is_addr(paddr, `UEFC_A_SCRATCH) && swap
               && enhanced_mode_select[1:0] == UEFC_CNT_ALT) alt_tx <= !alt_tx;
   end

   // Divisor bytes; fraction locked unless enhanced enable set
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         divisor_low_byte <= `UEFC_RST_DIV_LO;
         divisor_high_byte <= `UEFC_RST_ZERO;
         divisor_fraction <= `UEFC_RST_ZERO;
      end else if (wr_acc) begin
         if (is_addr(paddr, `UEFC_A_DIV_LO)) divisor_low_byte <= pwdata[7:0];
         if (is_addr(paddr, `UEFC_A_DIV_HI)) divisor_high_byte <= pwdata[7:0];
         if (is_addr(paddr, `UEFC_A_DIV_FRAC) && extended_feature_enable[`UEFC_EXT_ENH])
            divisor_fraction <= pwdata[7:0];
      end
   end

   // Divisor in sixteenths
   always_ff @(posedge ref_clk) begin
      if (srst) baud_divisor_x16 <= 20'h0_0010;
      else baud_divisor_x16 <= {divisor_high_byte, divisor_low_byte, divisor_fraction[3:0]};
   end

   // Feature and extended enable registers
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         feature_control <= `UEFC_RST_ZERO;
         extended_feature_enable <= `UEFC_RST_ZERO;
      end else if (wr_acc) begin
         if (is_addr(paddr, `UEFC_A_FEAT)) feature_control <= pwdata[7:0];
         if (is_addr(paddr, `UEFC_A_EXT_EN)) extended_feature_enable <= pwdata[7:0];
      end
   end

   // Custom trigger levels, routed by select bit
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         tx_trigger_level <= `UEFC_RST_ZERO;
         rx_trigger_level <= `UEFC_RST_ZERO;
      end else if (wr_acc && is_addr(paddr, `UEFC_A_TRIG)) begin
         if (feature_control[`UEFC_FEAT_TRG_TX]) tx_trigger_level <= pwdata[7:0];
         else rx_trigger_level <= pwdata[7:0];
      end
   end

   // Mode outputs to the UART core
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sample_16x <= 1'b1;
         trigger_table <= 2'b00;
         sw_flow_select <= 4'h0;
         special_char_en <= 1'b0;
         auto_rts_en <= 1'b0;
         auto_cts_en <= 1'b0;
      end else begin
         sample_16x <= enhanced_mode_select[`UEFC_EMS_SAMP16];
         trigger_table <= feature_control[5:4];
         sw_flow_select <= extended_feature_enable[3:0]; // Dual chars matched in sequence
         special_char_en <= extended_feature_enable[`UEFC_EXT_SPECIAL];
         auto_rts_en <= extended_feature_enable[`UEFC_EXT_ARTS];
         auto_cts_en <= extended_feature_enable[`UEFC_EXT_ACTS];
      end
   end

   // Receive pin synchroniser and IR polarity
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rx_meta <= 1'b0;
         rx_sync <= 1'b0;
         rx_data_in <= 1'b0;
      end else begin
         rx_meta <= rx_pin;
         rx_sync <= rx_meta;
         rx_data_in <= rx_sync ^ feature_control[`UEFC_FEAT_IR_INV];
      end
   end

   // Immediate error pending; set wins over clear
   always_ff @(posedge ref_clk) begin
      if (srst) err_pend <= 1'b0;
      else if (rx_err_push) err_pend <= 1'b1;
      else if (lsr_read) err_pend <= 1'b0;
   end

   // Line error interrupt, delayed or immediate
   always_ff @(posedge ref_clk) begin
      if (srst) lsr_int <= 1'b0;
      else if (enhanced_mode_select[`UEFC_EMS_LSR_IMM]) lsr_int <= err_pend || rx_err_push;
      else lsr_int <= rhr_err;
   end

   // Transmit interrupt source
   always_ff @(posedge ref_clk) begin
      if (srst) tx_int <= 1'b0;
      else tx_int <= feature_control[`UEFC_FEAT_RS485] ? tx_idle : tx_thr_empty;
   end

   uefc_dir_ctrl u_dir (
      .ref_clk(ref_clk),
      .srst(srst),
      .invert(enhanced_mode_select[`UEFC_EMS_DIR_INV]),
      .tx_load(tx_load),
      .tx_idle(tx_idle),
      .bit_tick(bit_tick),
      .dir_out(dir_raw)
   );

   uefc_rts_ctrl u_rts (
      .ref_clk(ref_clk),
      .srst(srst),
      .auto_en(extended_feature_enable[`UEFC_EXT_ARTS]),
      .manual_n(rts_manual_n),
      .hyst_code({enhanced_mode_select[5:4], feature_control[1:0]}),
      .rx_trig(rx_trigger_level),
      .rx_count(rx_fifo_count),
      .rts_flow_n(rts_flow_n)
   );

   // RTS pin: direction control overrides flow control
   always_ff @(posedge ref_clk) begin
      if (srst) rts_n <= 1'b1;
      else rts_n <= feature_control[`UEFC_FEAT_RS485] ? dir_raw : rts_flow_n;
   end

   a_frac_locked: assert property (@(posedge ref_clk) disable iff (srst)
      wr_acc && is_addr(paddr, `UEFC_A_DIV_FRAC) && !extended_feature_enable[`UEFC_EXT_ENH]
      |=> $stable(divisor_fraction))
      else $error("fraction written while locked");
   a_reset_values: assert property (@(posedge ref_clk)
      srst |=> feature_control == 8'h00 && enhanced_mode_select == 8'h80 && sample_16x ##1 sample_16x)
      else $error("reset values wrong");
   a_alt_order: assert property (@(posedge ref_clk) disable iff (srst)
      wr_acc && is_addr(paddr, `UEFC_A_SCRATCH) && swap && pwdata[1:0] == 2'b11
      |=> !alt_tx && fifo_level_readout == rx_fifo_count)
      else $error("alternating readout did not restart with RX");
   a_alt_toggle: assert property (@(posedge ref_clk) disable iff (srst)
      rd_acc && is_addr(paddr, `UEFC_A_SCRATCH) && swap && enhanced_mode_select[1:0] == 2'b11
      |=> alt_tx != $past(alt_tx))
      else $error("alternating readout did not advance");
   a_occ_key: assert property (@(posedge ref_clk) disable iff (srst)
      rd_setup && is_addr(paddr, `UEFC_A_OCC_CNT) && line_control != 8'hBF
      |=> pslverr && prdata == 32'h0000_0000)
      else $error("occupancy count read without key");
   a_swap_read: assert property (@(posedge ref_clk) disable iff (srst)
      rd_setup && is_addr(paddr, `UEFC_A_SCRATCH) && swap |=> prdata[7:0] == $past(fifo_level_readout))
      else $error("swapped scratch read wrong");
   a_trig_route: assert property (@(posedge ref_clk) disable iff (srst)
      wr_acc && is_addr(paddr, `UEFC_A_TRIG) && feature_control[7]
      |=> tx_trigger_level == $past(pwdata[7:0]) && $stable(rx_trigger_level))
      else $error("trigger level routed wrong");
   a_lsr_imm: assert property (@(posedge ref_clk) disable iff (srst)
      enhanced_mode_select[6] && rx_err_push |=> lsr_int)
      else $error("immediate line interrupt missing");
   a_lsr_delay: assert property (@(posedge ref_clk) disable iff (srst)
      !enhanced_mode_select[6] |=> lsr_int == $past(rhr_err))
      else $error("delayed line interrupt wrong");
   a_tx_int_wait: assert property (@(posedge ref_clk) disable iff (srst)
      feature_control[3] && !tx_idle |=> !tx_int)
      else $error("transmit interrupt before shifter empty");
   a_ir_invert: assert property (@(posedge ref_clk) disable iff (srst)
      $stable(feature_control[2]) |=> rx_data_in == ($past(rx_sync) ^ $past(feature_control[2])))
      else $error("IR receive polarity wrong");
endmodule : uefc_top

// [testbench/uefc_core_model.sv]
// Transmit side of the UART core: FIFO count, shifter, bit ticks
// Assumes one push pulse per byte from the bench, on ref_clk
`timescale 1ns/100ps
module uefc_core_model
   import uefc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic push,
   output logic tx_load,
   output logic tx_thr_empty,
   output logic tx_idle,
   output logic bit_tick,
   output uefc_byte_t tx_fifo_count
);
   uefc_byte_t cnt;
   logic [3:0] bits;
   logic [1:0] div;
   // FIFO feeds a ten-bit shifter, one bit every four cycles
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cnt <= 8'h00;
         bits <= 4'h0;
         div <= 2'h0;
      end else begin
         div <= div + 2'h1;
         if (cnt != 8'h00 && bits == 4'h0) begin
            bits <= 4'hA;
            cnt <= cnt - 8'h01 + {7'h00, push};
         end else begin
            cnt <= cnt + {7'h00, push};
            if (bit_tick && bits != 4'h0) bits <= bits - 4'h1;
         end
      end
   end
   // Status seen by the control block
   assign bit_tick = (div == 2'h3);
   assign tx_load = push;
   assign tx_thr_empty = (cnt == 8'h00);
   assign tx_idle = (cnt == 8'h00) && (bits == 4'h0);
   assign tx_fifo_count = cnt;
endmodule : uefc_core_model

// [testbench/tb_top.sv]
// Register and pin tests of the enhanced feature control block
// Assumes the core model on the transmit side; bench drives the rest
`timescale 1ns/100ps
`include "uefc_map.svh"
module tb_top;
   import uefc_pkg::*;
   logic ref_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, push = 0;
   logic rx_err_push = 0, rhr_err = 0, lsr_read = 0, rx_pin = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd_v;
   logic pready, pslverr, rd_e, tx_load, tx_thr_empty, tx_idle, bit_tick, rts_n, tx_int, lsr_int;
   logic rx_data_in, sample_16x, special_char_en, auto_rts_en, auto_cts_en;
   logic [19:0] baud_divisor_x16;
   logic [1:0] trigger_table;
   logic [3:0] sw_flow_select;
   uefc_byte_t rx_fifo_count = 8'h07, tx_fifo_count, tx_trigger_level, rx_trigger_level;
   int errors = 0, n_tests = 0, cyc = 0;
   // Identity values are arbitrary
   uefc_top #(.PART_ID(8'h3A), .PART_REV(8'h02)) dut (.ref_clk(ref_clk), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_fifo_count(rx_fifo_count), .tx_fifo_count(tx_fifo_count), .tx_load(tx_load),
      .tx_thr_empty(tx_thr_empty), .tx_idle(tx_idle), .bit_tick(bit_tick), .rx_err_push(rx_err_push),
      .rhr_err(rhr_err), .lsr_read(lsr_read), .rts_manual_n(1'b0), .rx_pin(rx_pin), .rts_n(rts_n),
      .tx_int(tx_int), .lsr_int(lsr_int), .rx_data_in(rx_data_in), .sample_16x(sample_16x),
      .baud_divisor_x16(baud_divisor_x16), .trigger_table(trigger_table), .tx_trigger_level(tx_trigger_level),
      .rx_trigger_level(rx_trigger_level), .sw_flow_select(sw_flow_select), .special_char_en(special_char_en),
      .auto_rts_en(auto_rts_en), .auto_cts_en(auto_cts_en));
   uefc_core_model core (.ref_clk(ref_clk), .srst(srst), .push(push), .tx_load(tx_load),
      .tx_thr_empty(tx_thr_empty), .tx_idle(tx_idle), .bit_tick(bit_tick), .tx_fifo_count(tx_fifo_count));
   // Clock and run limit
   always #2 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors = errors + 1;
         report_and_stop();
      end
   end
   task report_and_stop();
      if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // One APB transfer, held until pready is seen, then one idle cycle
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd_v = prdata;
      rd_e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask : apb
   task wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask : wr
   task rd(input string nm, input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, rd_v, {24'h0, e});
   endtask : rd
   task wt(input logic v);
      int k;
      k = 0;
      while (rts_n !== v && k < 300) begin
         @(posedge ref_clk);
         k++;
      end
      chk("rts_n", rts_n, v);
   endtask : wt
   task step(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : step
   task pulse_push();
      push <= 1'b1;
      @(posedge ref_clk);
      push <= 1'b0;
   endtask : pulse_push
   initial begin
      step(2);
      srst <= 1'b0;
      @(posedge ref_clk);
      chk("reset div", baud_divisor_x16, 20'h00010);
      chk("reset 16x", sample_16x, 1'b1);
      rd("scratch reset", `UEFC_A_SCRATCH, 8'hFF);
      rd("feature reset", `UEFC_A_FEAT, 8'h00);
      wr(`UEFC_A_SCRATCH, 8'h5A);
      rd("scratch", `UEFC_A_SCRATCH, 8'h5A);
      wr(`UEFC_A_DIV_FRAC, 8'h05);
      rd("frac locked", `UEFC_A_DIV_FRAC, 8'h00);
      wr(`UEFC_A_EXT_EN, 8'h10); // Enhanced enable before fraction
      wr(`UEFC_A_DIV_FRAC, 8'h05);
      wr(`UEFC_A_DIV_LO, 8'h34);
      wr(`UEFC_A_DIV_HI, 8'h12);
      step(1); // Divisor output settles one edge after the write
      chk("divisor", baud_divisor_x16, 20'h12345);
      wr(`UEFC_A_DIV_LO, 8'h00); // Integer bytes zeroed before identity reads
      wr(`UEFC_A_DIV_HI, 8'h00);
      rd("part id", `UEFC_A_PART_ID, 8'h3A);
      rd("part rev", `UEFC_A_PART_REV, 8'h02);
      wr(`UEFC_A_PART_ID, 8'h00);
      chk("id write err", rd_e, 1'b1);
      apb(1'b0, 8'h3C, 32'h0);
      chk("unmapped err", rd_e, 1'b1);
      wr(`UEFC_A_FEAT, 8'hB0); // Transmit level first, table D
      wr(`UEFC_A_TRIG, 8'h20);
      chk("tx trig", tx_trigger_level, 8'h20);
      chk("table", trigger_table, 2'b11);
      wr(`UEFC_A_FEAT, 8'h21);
      wr(`UEFC_A_TRIG, 8'h10);
      chk("rx trig", rx_trigger_level, 8'h10);
      chk("table", trigger_table, 2'b10);
      wr(`UEFC_A_EXT_EN, 8'h50);
      rx_fifo_count <= 8'h14;
      wt(1'b1); // Upper level 16+4
      rx_fifo_count <= 8'h0C;
      step(6);
      chk("rts at lower", rts_n, 1'b1);
      rx_fifo_count <= 8'h0B;
      wt(1'b0);
      rx_fifo_count <= 8'h07;
      wr(`UEFC_A_EXT_EN, 8'h00); // Flow control cleared before a new setting
      wr(`UEFC_A_EXT_EN, 8'hBB);
      step(1);
      chk("ext outputs", {auto_cts_en, auto_rts_en, special_char_en, sw_flow_select}, 32'h5B);
      wr(`UEFC_A_EXT_EN, 8'h10);
      apb(1'b0, `UEFC_A_OCC_CNT, 32'h0);
      chk("occ no key", rd_e, 1'b1);
      wr(`UEFC_A_LINE_CTRL, `UEFC_LCR_KEY); // Read while traffic is stopped
      rd("occ rx", `UEFC_A_OCC_CNT, 8'h07);
      wr(`UEFC_A_LINE_CTRL, 8'h00);
      rhr_err <= 1'b1;
      step(3);
      chk("lsr delayed", lsr_int, 1'b1);
      rhr_err <= 1'b0;
      rx_pin <= 1'b1;
      step(4);
      chk("lsr delayed off", lsr_int, 1'b0);
      chk("ir plain", rx_data_in, 1'b1);
      wr(`UEFC_A_FEAT, 8'h44);
      step(4);
      chk("ir inverted", rx_data_in, 1'b0);
      wr(`UEFC_A_SCRATCH, 8'h03);
      step(1); // Sampling output settles one edge after the write
      chk("8x", sample_16x, 1'b0);
      rd("alt rx", `UEFC_A_SCRATCH, 8'h07);
      rd("alt tx", `UEFC_A_SCRATCH, 8'h00);
      rd("alt rx", `UEFC_A_SCRATCH, 8'h07);
      wr(`UEFC_A_SCRATCH, 8'h01);
      rd("tx mode", `UEFC_A_SCRATCH, 8'h00);
      wr(`UEFC_A_SCRATCH, 8'hC0);
      rd("rx mode", `UEFC_A_SCRATCH, 8'h07);
      wr(`UEFC_A_SCRATCH, 8'hC2);
      rd("rx2 mode", `UEFC_A_SCRATCH, 8'h07);
      rx_err_push <= 1'b1;
      @(posedge ref_clk);
      rx_err_push <= 1'b0;
      step(2);
      chk("lsr immediate", lsr_int, 1'b1);
      lsr_read <= 1'b1;
      @(posedge ref_clk);
      lsr_read <= 1'b0;
      step(2);
      chk("lsr cleared", lsr_int, 1'b0);
      wr(`UEFC_A_FEAT, 8'h08);
      wt(1'b1); // Receive level
      pulse_push();
      wt(1'b0);
      step(12);
      chk("tx int shifting", tx_int, 1'b0);
      wt(1'b1);
      chk("idle at rise", tx_idle, 1'b1);
      chk("tx int idle", tx_int, 1'b1);
      wr(`UEFC_A_FEAT, 8'h48);
      wr(`UEFC_A_SCRATCH, 8'h88);
      wt(1'b0); // Inverted receive level
      pulse_push();
      wt(1'b1);
      report_and_stop();
   end
endmodule : tb_top
